/* File: logic/tmal_core.sv */
// Alarm, fault queue, conversion control and register map of the temperature monitor
`timescale 1ns/1ps
`default_nettype none

module tmal_core #(
    parameter bit          ALT_VARIANT   = 1'b0,
    parameter logic [6:0]  OWN_ADDR      = 7'h2a,
    parameter logic [7:0]  MAKER_ID      = 8'h3c,
    parameter logic [7:0]  VERSION_ID    = 8'h01,
    parameter int unsigned FAST_CYCLES   = tmal_pkg::FAST_INTERVAL_CYCLES
) (
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic       link_clk,
    input  wire logic       tr_valid,
    input  wire logic [2:0] tr_kind,
    input  wire logic [7:0] tr_cmd,
    input  wire logic [7:0] tr_data,
    output var  logic       tr_ready,
    output var  logic       rsp_valid,
    output var  logic [7:0] rsp_data,
    output var  logic       rsp_ack,
    output var  logic       conv_start,
    input  wire logic       conv_done,
    input  wire logic [7:0] conv_local_temp,
    input  wire logic [2:0] conv_local_frac,
    input  wire logic [7:0] conv_remote_temp,
    input  wire logic [2:0] conv_remote_frac,
    input  wire logic       diode_open,
    input  wire logic       diode_short,
    output var  logic       alert_out,
    output var  logic       alert_oe,
    output var  logic       overtemp_output_local,
    output var  logic       overtemp_output_remote
);

    // ------------------------------------------------------------
    // Parameter checks
    // ------------------------------------------------------------
    if (FAST_CYCLES < 1 || FAST_CYCLES > 32'h03ffffff) begin : g_bad_interval
        $error("FAST_CYCLES out of range");
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0]                 cmd_ptr;
        logic                       cfg_mask;
        logic                       cfg_stby;
        logic [7:0]                 rate;
        logic [7:0]                 local_high;
        logic [7:0]                 local_low;
        logic [7:0]                 remote_high;
        logic [7:0]                 remote_low;
        logic [7:0]                 remote_ot;
        logic [7:0]                 local_ot;
        logic [7:0]                 margin;
        logic [7:0]                 queue;
        logic [7:0]                 local_temp;
        logic [7:0]                 remote_temp;
        logic [7:0]                 local_frac;
        logic [7:0]                 remote_frac;
        logic [4:0]                 flags;
        logic [4:0]                 cause;
        logic [1:0]                 fault_cnt;
        logic                       alert_latch;
        logic                       alert_oe;
        logic                       ot_local;
        logic                       ot_remote;
        tmal_pkg::tmal_conv_state_t state;
        logic                       one_shot_run;
        logic                       conv_start;
        logic [31:0]                timer;
        logic                       req_s1;
        logic                       req_s2;
        logic                       req_s3;
        logic                       ack_tog;
        logic [7:0]                 rsp_data;
        logic                       rsp_ack;
    } tmal_core_t;

    typedef struct packed {
        logic       req_tog;
        logic [2:0] kind;
        logic [7:0] cmd;
        logic [7:0] data;
        logic       ack_s1;
        logic       ack_s2;
        logic       ack_s3;
        logic       tr_ready;
        logic       rsp_valid;
        logic [7:0] rsp_data;
        logic       rsp_ack;
    } tmal_link_t;

    localparam tmal_core_t CORE_RST = '{
        cmd_ptr:      tmal_pkg::RST_CMD_PTR,
        cfg_mask:     1'b0,
        cfg_stby:     1'b0,
        rate:         tmal_pkg::RST_RATE,
        local_high:   tmal_pkg::RST_LOCAL_HIGH,
        local_low:    tmal_pkg::RST_LOW_LIMIT,
        remote_high:  ALT_VARIANT ? tmal_pkg::RST_REMOTE_HIGH_B : tmal_pkg::RST_REMOTE_HIGH_A,
        remote_low:   tmal_pkg::RST_LOW_LIMIT,
        remote_ot:    ALT_VARIANT ? tmal_pkg::RST_REMOTE_OT_B : tmal_pkg::RST_REMOTE_OT_A,
        local_ot:     tmal_pkg::RST_LOCAL_OT,
        margin:       tmal_pkg::RST_RETURN_MARGIN,
        queue:        tmal_pkg::RST_QUEUE,
        state:        tmal_pkg::TMAL_ST_IDLE,
        default:      '0
    };

    tmal_core_t c;
    tmal_core_t next_c;
    tmal_link_t l;
    tmal_link_t next_l;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] interval_of(input logic [7:0] rate);
        logic [2:0] code;
        logic [2:0] sh;
        code = rate[tmal_pkg::RATE_CODE_MSB:0];
        sh   = (code >= tmal_pkg::RATE_FASTEST_CODE) ? 3'h0
                                                      : 3'(tmal_pkg::RATE_FASTEST_CODE - code);
        return 32'(FAST_CYCLES) << sh;
    endfunction : interval_of

    function automatic logic overtemp_next(input logic [7:0] t, input logic [7:0] lim,
                                           input logic [7:0] overtemp_return_margin, input logic now);
        logic signed [8:0] rel;
        rel = $signed({lim[7], lim}) - $signed({1'b0, overtemp_return_margin});
        if ($signed(t) >= $signed(lim)) begin
            return 1'b1;
        end else if ($signed({t[7], t}) < rel) begin
            return 1'b0;
        end
        return now;
    endfunction : overtemp_next

    // ------------------------------------------------------------
    // Core domain
    // ------------------------------------------------------------
    always_comb begin
        logic [7:0] addr;
        logic [7:0] rd;
        logic       req;
        logic       one_shot;
        logic       status_rd;
        logic       fault;
        logic [7:0] rt;
        logic [4:0] cause;
        logic       bad;
        logic [1:0] need;
        logic [1:0] cnt;
        addr      = 8'h00;
        rd        = 8'h00;
        one_shot  = 1'b0;
        status_rd = 1'b0;
        fault     = 1'b0;
        rt        = 8'h00;
        cause     = c.cause;
        bad       = 1'b0;
        need      = 2'h1;
        cnt       = 2'h0;
        next_c    = c;
        next_c.conv_start = 1'b0;
        next_c.req_s1     = l.req_tog;
        next_c.req_s2     = c.req_s1;
        next_c.req_s3     = c.req_s2;
        req = c.req_s2 ^ c.req_s3;

        // Host transaction, one per request toggle
        if (req) begin
            next_c.ack_tog  = ~c.ack_tog;
            next_c.rsp_ack  = 1'b1;
            next_c.rsp_data = 8'h00;
            addr = (l.kind == tmal_pkg::KIND_RECV_BYTE) ? c.cmd_ptr : l.cmd;
            unique case (addr)
                tmal_pkg::CMD_LOCAL_TEMP_READ:        rd = c.local_temp;
                tmal_pkg::CMD_REMOTE_TEMP_READ:       rd = c.remote_temp;
                tmal_pkg::CMD_ALARM_FLAGS_READ:
                    rd = {c.state == tmal_pkg::TMAL_ST_CONV, c.flags,
                          c.ot_remote, c.ot_local};
                tmal_pkg::CMD_CONFIG_READ:            rd = {c.cfg_mask, c.cfg_stby, 6'h00};
                tmal_pkg::CMD_RATE_READ:              rd = c.rate;
                tmal_pkg::CMD_LOCAL_HIGH_LIMIT_READ:  rd = c.local_high;
                tmal_pkg::CMD_LOCAL_LOW_LIMIT_READ:   rd = c.local_low;
                tmal_pkg::CMD_REMOTE_HIGH_LIMIT_READ: rd = c.remote_high;
                tmal_pkg::CMD_REMOTE_LOW_LIMIT_READ:  rd = c.remote_low;
                tmal_pkg::CMD_REMOTE_FRACTION_READ:   rd = c.remote_frac;
                tmal_pkg::CMD_LOCAL_FRACTION_READ:    rd = c.local_frac;
                tmal_pkg::CMD_REMOTE_OVERTEMP_LIMIT:  rd = c.remote_ot;
                tmal_pkg::CMD_LOCAL_OVERTEMP_LIMIT:   rd = c.local_ot;
                tmal_pkg::CMD_OVERTEMP_RETURN_MARGIN: rd = c.margin;
                tmal_pkg::CMD_CONSECUTIVE_FAULT_COUNT: rd = c.queue;
                tmal_pkg::CMD_MAKER_CODE:             rd = MAKER_ID;
                tmal_pkg::CMD_SILICON_VERSION:        rd = VERSION_ID;
                default:                              rd = 8'h00;
            endcase
            unique case (l.kind)
                tmal_pkg::KIND_WRITE_BYTE: begin
                    next_c.cmd_ptr = l.cmd;
                    unique case (l.cmd)
                        tmal_pkg::CMD_CONFIG_WRITE: begin
                            next_c.cfg_mask = l.data[tmal_pkg::CFG_MASK_BIT];
                            next_c.cfg_stby = l.data[tmal_pkg::CFG_STBY_BIT];
                        end
                        tmal_pkg::CMD_RATE_WRITE:              next_c.rate = l.data;
                        tmal_pkg::CMD_LOCAL_HIGH_LIMIT_WRITE:  next_c.local_high = l.data;
                        tmal_pkg::CMD_LOCAL_LOW_LIMIT_WRITE:   next_c.local_low = l.data;
                        tmal_pkg::CMD_REMOTE_HIGH_LIMIT_WRITE: next_c.remote_high = l.data;
                        tmal_pkg::CMD_REMOTE_LOW_LIMIT_WRITE:  next_c.remote_low = l.data;
                        tmal_pkg::CMD_REMOTE_OVERTEMP_LIMIT:   next_c.remote_ot = l.data;
                        tmal_pkg::CMD_LOCAL_OVERTEMP_LIMIT:    next_c.local_ot = l.data;
                        tmal_pkg::CMD_OVERTEMP_RETURN_MARGIN:  next_c.margin = l.data;
                        tmal_pkg::CMD_CONSECUTIVE_FAULT_COUNT: next_c.queue = l.data;
                        tmal_pkg::CMD_SINGLE_CONVERSION:       one_shot = 1'b1;
                        default:                               next_c.rsp_ack = 1'b0;
                    endcase
                end
                tmal_pkg::KIND_SEND_BYTE: begin
                    next_c.cmd_ptr = l.cmd;
                    one_shot = (l.cmd == tmal_pkg::CMD_SINGLE_CONVERSION);
                end
                tmal_pkg::KIND_READ_BYTE, tmal_pkg::KIND_RECV_BYTE: begin
                    if (l.kind == tmal_pkg::KIND_READ_BYTE) begin
                        next_c.cmd_ptr = l.cmd;
                    end
                    next_c.rsp_data = rd;
                    status_rd = (addr == tmal_pkg::CMD_ALARM_FLAGS_READ);
                end
                tmal_pkg::KIND_ALERT_READ: begin
                    next_c.rsp_ack  = c.alert_latch;
                    next_c.rsp_data = {OWN_ADDR, 1'b1};
                end
                tmal_pkg::KIND_ALERT_WON: begin
                    if (c.cause[4:1] == 4'h0 && (!ALT_VARIANT || !c.cause[0])) begin
                        next_c.alert_latch = 1'b0;
                    end
                end
                default: next_c.rsp_ack = 1'b0;
            endcase
        end

        // Status read clears only flags whose cause is gone
        if (status_rd && c.state == tmal_pkg::TMAL_ST_IDLE) begin
            next_c.flags = c.flags & c.cause;
            if (c.cause[4:1] == 4'h0 && (!ALT_VARIANT || !c.cause[0])) begin
                next_c.alert_latch = 1'b0;
            end
        end

        // Conversion scheduling
        if (c.timer != 32'h0) begin
            next_c.timer = c.timer - 32'h1;
        end
        unique case (c.state)
            tmal_pkg::TMAL_ST_IDLE: begin
                if (one_shot) begin
                    next_c.state        = tmal_pkg::TMAL_ST_CONV;
                    next_c.conv_start   = 1'b1;
                    next_c.one_shot_run = 1'b1;
                    next_c.timer        = interval_of(c.rate);
                end else if (!c.cfg_stby && c.timer == 32'h0) begin
                    next_c.state      = tmal_pkg::TMAL_ST_CONV;
                    next_c.conv_start = 1'b1;
                    next_c.timer      = interval_of(c.rate);
                end
            end
            tmal_pkg::TMAL_ST_CONV: begin
                // One-shot requests arriving here are dropped
                if (conv_done) begin
                    next_c.state        = tmal_pkg::TMAL_ST_IDLE;
                    next_c.one_shot_run = 1'b0;
                    fault = diode_open | diode_short;
                    rt = fault ? tmal_pkg::FAULT_TEMP : conv_remote_temp;
                    next_c.local_temp  = conv_local_temp;
                    next_c.remote_temp = rt;
                    next_c.local_frac  = {conv_local_frac, 5'h00};
                    next_c.remote_frac = fault ? 8'h00 : {conv_remote_frac, 5'h00};
                    cause = {$signed(conv_local_temp) >= $signed(c.local_high),
                             $signed(conv_local_temp) < $signed(c.local_low),
                             $signed(rt) >= $signed(c.remote_high),
                             $signed(rt) < $signed(c.remote_low),
                             diode_open};
                    next_c.cause = cause;
                    // A status read during a conversion clears nothing; new causes are ORed in
                    next_c.flags = next_c.flags | cause;
                    next_c.ot_local  = overtemp_next(conv_local_temp, c.local_ot,
                                                     c.margin, c.ot_local);
                    next_c.ot_remote = overtemp_next(rt, c.remote_ot,
                                                     c.margin, c.ot_remote);
                    bad = (cause[4:1] != 4'h0) || (ALT_VARIANT && cause[0]);
                    unique case ({c.queue[tmal_pkg::QUEUE_UPPER_BIT],
                                  c.queue[tmal_pkg::QUEUE_LOWER_BIT]})
                        2'b01:   need = 2'h2;
                        2'b11:   need = 2'h3;
                        default: need = 2'h1;
                    endcase
                    cnt = bad ? ((c.fault_cnt == 2'h3) ? 2'h3 : 2'(c.fault_cnt + 2'h1)) : 2'h0;
                    next_c.fault_cnt = cnt;
                    if (bad && cnt >= need) begin
                        next_c.alert_latch = 1'b1;
                    end
                end
            end
            default: next_c.state = tmal_pkg::TMAL_ST_IDLE;
        endcase

        next_c.alert_oe = next_c.alert_latch & ~next_c.cfg_mask;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            c <= CORE_RST;
        end else begin
            c <= next_c;
        end
    end

    // ------------------------------------------------------------
    // Link domain
    // ------------------------------------------------------------
    always_comb begin
        next_l           = l;
        next_l.ack_s1    = c.ack_tog;
        next_l.ack_s2    = l.ack_s1;
        next_l.ack_s3    = l.ack_s2;
        next_l.rsp_valid = 1'b0;
        if (tr_valid && l.tr_ready) begin
            next_l.kind     = tr_kind;
            next_l.cmd      = tr_cmd;
            next_l.data     = tr_data;
            next_l.req_tog  = ~l.req_tog;
            next_l.tr_ready = 1'b0;
        end else if (!l.tr_ready && (l.ack_s2 ^ l.ack_s3)) begin
            next_l.rsp_valid = 1'b1;
            next_l.rsp_data  = c.rsp_data;
            next_l.rsp_ack   = c.rsp_ack;
            next_l.tr_ready  = 1'b1;
        end
    end

    always_ff @(posedge link_clk or negedge nrst) begin
        if (!nrst) begin
            l <= '{tr_ready: 1'b1, default: '0};
        end else begin
            l <= next_l;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign tr_ready               = l.tr_ready;
    assign rsp_valid              = l.rsp_valid;
    assign rsp_data               = l.rsp_data;
    assign rsp_ack                = l.rsp_ack;
    assign conv_start             = c.conv_start;
    assign alert_out              = 1'b0;
    assign alert_oe               = c.alert_oe;
    assign overtemp_output_local  = c.ot_local;
    assign overtemp_output_remote = c.ot_remote;

endmodule : tmal_core

`default_nettype wire

/* File: pkg/tmal_pkg.sv */
// Constants, codes and types shared by the temperature monitor alarm logic
package tmal_pkg;

    // ------------------------------------------------------------
    // Command codes (register pointer values)
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_LOCAL_TEMP_READ       = 8'h00;
    localparam logic [7:0] CMD_REMOTE_TEMP_READ      = 8'h01;
    localparam logic [7:0] CMD_ALARM_FLAGS_READ      = 8'h02;
    localparam logic [7:0] CMD_CONFIG_READ           = 8'h03;
    localparam logic [7:0] CMD_RATE_READ             = 8'h04;
    localparam logic [7:0] CMD_LOCAL_HIGH_LIMIT_READ = 8'h05;
    localparam logic [7:0] CMD_LOCAL_LOW_LIMIT_READ  = 8'h06;
    localparam logic [7:0] CMD_REMOTE_HIGH_LIMIT_READ = 8'h07;
    localparam logic [7:0] CMD_REMOTE_LOW_LIMIT_READ = 8'h08;
    localparam logic [7:0] CMD_CONFIG_WRITE          = 8'h09;
    localparam logic [7:0] CMD_RATE_WRITE            = 8'h0a;
    localparam logic [7:0] CMD_LOCAL_HIGH_LIMIT_WRITE = 8'h0b;
    localparam logic [7:0] CMD_LOCAL_LOW_LIMIT_WRITE = 8'h0c;
    localparam logic [7:0] CMD_REMOTE_HIGH_LIMIT_WRITE = 8'h0d;
    localparam logic [7:0] CMD_REMOTE_LOW_LIMIT_WRITE = 8'h0e;
    localparam logic [7:0] CMD_SINGLE_CONVERSION     = 8'h0f;
    localparam logic [7:0] CMD_REMOTE_FRACTION_READ  = 8'h10;
    localparam logic [7:0] CMD_LOCAL_FRACTION_READ   = 8'h11;
    localparam logic [7:0] CMD_REMOTE_OVERTEMP_LIMIT = 8'h19;
    localparam logic [7:0] CMD_LOCAL_OVERTEMP_LIMIT  = 8'h20;
    localparam logic [7:0] CMD_OVERTEMP_RETURN_MARGIN = 8'h21;
    localparam logic [7:0] CMD_CONSECUTIVE_FAULT_COUNT = 8'h22;
    localparam logic [7:0] CMD_MAKER_CODE            = 8'hfe;
    localparam logic [7:0] CMD_SILICON_VERSION       = 8'hff;

    // ------------------------------------------------------------
    // Values after reset, and the remote reading on a diode fault
    // ------------------------------------------------------------
    localparam logic [7:0] RST_CMD_PTR        = 8'h00;
    localparam logic [7:0] RST_RATE           = 8'h07;
    localparam logic [7:0] RST_LOCAL_HIGH     = 8'h55;
    localparam logic [7:0] RST_REMOTE_HIGH_A  = 8'h5f;
    localparam logic [7:0] RST_REMOTE_HIGH_B  = 8'h55;
    localparam logic [7:0] RST_LOW_LIMIT      = 8'h00;
    localparam logic [7:0] RST_LOCAL_OT       = 8'h55;
    localparam logic [7:0] RST_REMOTE_OT_A    = 8'h7d;
    localparam logic [7:0] RST_REMOTE_OT_B    = 8'h55;
    localparam logic [7:0] RST_RETURN_MARGIN  = 8'h0a;
    localparam logic [7:0] RST_QUEUE          = 8'h86;
    localparam logic [7:0] FAULT_TEMP         = 8'hff;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CFG_MASK_BIT   = 7;
    localparam int CFG_STBY_BIT   = 6;
    localparam int QUEUE_UPPER_BIT = 2;
    localparam int QUEUE_LOWER_BIT = 1;
    localparam int RATE_CODE_MSB  = 2;
    localparam logic [2:0] RATE_FASTEST_CODE = 3'h6;

    // ------------------------------------------------------------
    // Link transaction kinds and addresses
    // ------------------------------------------------------------
    localparam logic [2:0] KIND_WRITE_BYTE = 3'h0;
    localparam logic [2:0] KIND_SEND_BYTE  = 3'h1;
    localparam logic [2:0] KIND_READ_BYTE  = 3'h2;
    localparam logic [2:0] KIND_RECV_BYTE  = 3'h3;
    localparam logic [2:0] KIND_ALERT_READ = 3'h4;
    localparam logic [2:0] KIND_ALERT_WON  = 3'h5;
    localparam logic [6:0] ALERT_RESPONSE_ADDR = 7'h0c;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS        = 50;
    localparam int unsigned FAST_INTERVAL_NS     = 250000000;
    localparam int unsigned FAST_INTERVAL_CYCLES = FAST_INTERVAL_NS / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        TMAL_ST_IDLE = 2'b01,
        TMAL_ST_CONV = 2'b10
    } tmal_conv_state_t;

endpackage : tmal_pkg

/* File: test/tmal_monitor.sv */
// Checker of link handshake and alarm output timing
`timescale 1ns/1ps
`default_nettype none
module tmal_monitor #(parameter logic [6:0] OWN_ADDR = 7'h2a) (
    input wire logic       clk,
    input wire logic       nrst,
    input wire logic       link_clk,
    input wire logic       tr_valid,
    input wire logic [2:0] tr_kind,
    input wire logic       tr_ready,
    input wire logic       rsp_valid,
    input wire logic [7:0] rsp_data,
    input wire logic       conv_start,
    input wire logic       conv_done,
    input wire logic       alert_oe,
    input wire logic       overtemp_output_local
);
    a_take_busy: assert property (@(posedge link_clk) disable iff (!nrst)
        tr_valid && tr_ready |=> !tr_ready) else $error("ready after take");
    a_rsp_bound: assert property (@(posedge link_clk) disable iff (!nrst)
        tr_valid && tr_ready |-> ##[2:12] rsp_valid) else $error("no answer");
    a_rsp_pulse: assert property (@(posedge link_clk) disable iff (!nrst)
        rsp_valid |=> !rsp_valid) else $error("answer too long");
    a_ready_back: assert property (@(posedge link_clk) disable iff (!nrst)
        rsp_valid |-> tr_ready) else $error("busy at answer");
    a_alert_addr: assert property (@(posedge link_clk) disable iff (!nrst)
        tr_valid && tr_ready && tr_kind == 3'h4 ##[2:7] rsp_valid
        |-> rsp_data == {OWN_ADDR, 1'b1}) else $error("alert answer address");
    a_conv_pulse: assert property (@(posedge clk) disable iff (!nrst)
        conv_start |=> !conv_start) else $error("start too long");
    a_ot_cause: assert property (@(posedge clk) disable iff (!nrst)
        $changed(overtemp_output_local) |-> $past(conv_done)) else $error("overtemp moved");
    a_alert_rise: assert property (@(posedge clk) disable iff (!nrst)
        $rose(alert_oe) |-> $past(conv_done) || $past(conv_done, 2)) else $error("alert rose");
endmodule : tmal_monitor
bind tmal_core tmal_monitor #(.OWN_ADDR(OWN_ADDR)) tmal_monitor_i (.clk(clk), .nrst(nrst),
    .link_clk(link_clk), .tr_valid(tr_valid), .tr_kind(tr_kind), .tr_ready(tr_ready),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .conv_start(conv_start),
    .conv_done(conv_done), .alert_oe(alert_oe), .overtemp_output_local(overtemp_output_local));
`default_nettype wire

/* File: test/tmal_host_model.sv */
// Host model issuing single-byte link transactions
`timescale 1ns/1ps
`default_nettype none
module tmal_host_model (
    input  wire logic       link_clk,
    input  wire logic       rsp_valid,
    input  wire logic [7:0] rsp_data,
    input  wire logic       rsp_ack,
    output var  logic       tr_valid,
    output var  logic [2:0] tr_kind,
    output var  logic [7:0] tr_cmd,
    output var  logic [7:0] tr_data
);
    initial {tr_valid, tr_kind, tr_cmd, tr_data} = 20'h0;
    task automatic xfer(input logic [2:0] k, input logic [7:0] c, input logic [7:0] d,
                        output logic [7:0] q, output logic a);
        int n;
        n = 0;
        @(posedge link_clk);
        tr_valid <= 1'b1;
        tr_kind <= k;
        tr_cmd <= c;
        tr_data <= (c == 8'h22) ? ((d & 8'h06) | 8'h80) : d;
        @(posedge link_clk);
        tr_valid <= 1'b0;
        tr_cmd <= ~c;
        tr_data <= ~d;
        do @(posedge link_clk); while (!rsp_valid && ++n < 40);
        q = rsp_data;
        a = rsp_ack;
    endtask : xfer
endmodule : tmal_host_model
`default_nettype wire

/* File: test/tb_top.sv */
// Top-level bench for the temperature monitor alarm logic
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic       clk = 1'b0, link_clk = 1'b0, nrst = 1'b0, conv_done = 1'b0, dopen = 1'b0, ak;
    logic       tr_valid, tr_ready, rsp_valid, rsp_ack, conv_start, alert_oe, ot_l;
    logic [2:0] tr_kind, cnt = 3'h0;
    logic [7:0] tr_cmd, tr_data, rsp_data, q, lt = 8'h19;
    logic [79:0] rc = 80'h0304_0506_0708_1920_2122, rv = 80'h0007_5500_5f00_7d55_0a86;
    int         err_count = 0, samples_checked = 0, cyc = 0, nstart = 0;
    always #25 clk = ~clk;
    initial begin #13; forever #80 link_clk = ~link_clk; end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        cnt <= conv_start ? 3'h4 : cnt - 3'(cnt != 3'h0);
        conv_done <= (cnt == 3'h1);
        nstart <= nstart + int'(conv_start);
        if (cyc == 30000) begin err_count++; report_and_stop(); end
    end
    tmal_core #(.FAST_CYCLES(20)) tmal_core_i (.clk(clk), .nrst(nrst), .link_clk(link_clk),
        .tr_valid(tr_valid), .tr_kind(tr_kind), .tr_cmd(tr_cmd), .tr_data(tr_data),
        .tr_ready(tr_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_ack(rsp_ack),
        .conv_start(conv_start), .conv_done(conv_done), .conv_local_temp(lt),
        .conv_local_frac(3'h5), .conv_remote_temp(8'h20), .conv_remote_frac(3'h2),
        .diode_open(dopen), .diode_short(1'b0), .alert_out(), .alert_oe(alert_oe),
        .overtemp_output_local(ot_l), .overtemp_output_remote());
    tmal_host_model tmal_host_model_i (.link_clk(link_clk), .rsp_valid(rsp_valid),
        .rsp_data(rsp_data), .rsp_ack(rsp_ack), .tr_valid(tr_valid), .tr_kind(tr_kind),
        .tr_cmd(tr_cmd), .tr_data(tr_data));
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin err_count++; $display("ERROR %s expected %h seen %h", n, e, g); end
    endtask : chk
    task automatic xf(input logic [2:0] k, input logic [7:0] c, input logic [7:0] d);
        tmal_host_model_i.xfer(k, c, d, q, ak);
        chk("answered", 8'h01, {7'h0, rsp_valid});
    endtask : xf
    task automatic shot(input int n);
        repeat (n) begin xf(3'h1, 8'h0f, 8'h00); repeat (10) @(posedge clk); end
    endtask : shot
    task automatic t_reset;
        xf(3'h3, 8'h00, 8'h00);
        chk("local temp", 8'h19, q);
        for (int i = 0; i < 10; i++) begin
            xf(3'h2, rc[79-8*i -: 8], 8'h00);
            chk("reset value", rv[79-8*i -: 8], q);
        end
        $display("TB: reset test done");
    endtask : t_reset
    task automatic t_alarm;
        int n0;
        xf(3'h0, 8'h09, 8'h40);
        xf(3'h0, 8'h30, 8'h00);
        chk("unmapped ack", 8'h00, {7'h0, ak});
        repeat (10) @(posedge clk) lt <= 8'h55;
        n0 = nstart;
        shot(2);
        chk("alert early", 8'h00, {7'h0, alert_oe});
        shot(1);
        chk("alert set", 8'h01, {7'h0, alert_oe});
        chk("starts", 8'h03, 8'(nstart - n0));
        xf(3'h2, 8'h02, 8'h00);
        chk("status", 8'h41, q);
        chk("alert held", 8'h01, {7'h0, alert_oe});
        @(posedge clk) lt <= 8'h4b;
        shot(1);
        chk("ot at margin", 8'h01, {7'h0, ot_l});
        @(posedge clk) lt <= 8'h4a;
        shot(1);
        chk("ot clear", 8'h00, {7'h0, ot_l});
        chk("alert latched", 8'h01, {7'h0, alert_oe});
        xf(3'h4, 8'h00, 8'h00);
        chk("alert answer", 8'h55, q);
        xf(3'h5, 8'h00, 8'h00);
        repeat (4) @(posedge clk);
        chk("alert clear", 8'h00, {7'h0, alert_oe});
        xf(3'h2, 8'h02, 8'h00);
        chk("flag shown", 8'h40, q);
        xf(3'h2, 8'h02, 8'h00);
        chk("flag cleared", 8'h00, q);
        $display("TB: alarm test done");
    endtask : t_alarm
    task automatic t_fault;
        @(posedge clk) dopen <= 1'b1;
        shot(1);
        xf(3'h2, 8'h01, 8'h00);
        chk("fault temp", 8'hff, q);
        xf(3'h2, 8'h02, 8'h00);
        chk("fault status", 8'h0c, q);
        $display("TB: fault test done");
    endtask : t_fault
    task automatic report_and_stop;
        $display("TB: checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : report_and_stop
    initial begin
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        repeat (20) @(posedge clk);
        t_reset();
        t_alarm();
        t_fault();
        report_and_stop();
    end
endmodule : tb_top
`default_nettype wire
